// [common/lcs_consts.vh]
`ifndef LCS_CONSTS_VH
`define LCS_CONSTS_VH

// bits per shift-register half and total row count
`define LCS_HALF_BITS 80
`define LCS_ROWS      160
`define LCS_HALF_HI   79
`define LCS_ROWS_HI   159

// two-bit level codes, most positive bias first
`define LCS_LVL_TOP    2'h0
`define LCS_LVL_SECOND 2'h1
`define LCS_LVL_THIRD  2'h2
`define LCS_LVL_BOTTOM 2'h3

// shift_direction_select encodings
`define LCS_DIR_UP   1'h0
`define LCS_DIR_DOWN 1'h1

// chain_oe_n patterns, low = driving; index 0 = bit 1, 1 = bit 80, 2 = bit 81, 3 = bit 160
`define LCS_OE_NONE 4'hf
`define LCS_OE_UP   4'h5
`define LCS_OE_DOWN 4'ha

`endif

// [rtl/lcs_level_sel.v]
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"

module lcs_level_sel (
    input  wire       scan_bit,
    input  wire       ac_phase,
    input  wire       blank_n,
    output reg  [1:0] level_code
);

    always @* begin
        if (!blank_n) begin
            level_code = `LCS_LVL_TOP;
        end else if (scan_bit) begin
            level_code = ac_phase ? `LCS_LVL_TOP : `LCS_LVL_BOTTOM;
        end else begin
            level_code = ac_phase ? `LCS_LVL_THIRD : `LCS_LVL_SECOND;
        end
    end

endmodule
`default_nettype wire

// [rtl/lcs_scan_driver.v]
// Functional notes
// - two 80-bit bidirectional shift register halves
// - shift once per scan clock falling edge
// - direction low: input bits 1/81, shift up
// - direction high: input bits 80/160, shift down
// - chain-end output lags input by 80 edges
// - each row output follows its register bit
// - blank high, bit high: select level by phase
// - blank high, bit low: non-select level by phase
// - blank low forces all rows to top level
`timescale 1ns/1ps
`default_nettype none
`include "lcs_consts.vh"

module lcs_scan_driver (
    input  wire                         core_clk,
    input  wire                         rst,
    input  wire                         scan_shift_clock,
    input  wire                         shift_direction_select,
    input  wire                         ac_phase_input,
    input  wire                         display_blank_n,
    // chain-end pins: index 0 = bit 1, 1 = bit 80, 2 = bit 81, 3 = bit 160
    input  wire [3:0]                   chain_in,
    output reg  [3:0]                   chain_out,
    output reg  [3:0]                   chain_oe_n,
    output wire [2*`LCS_ROWS-1:0]       row_level_outputs
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers; the scan clock is sampled, not used as a clock

    reg  [7:0] sync1_reg;
    reg  [7:0] sync2_reg;
    reg        clk_prev_reg;
    wire [7:0] raw_in = {scan_shift_clock, shift_direction_select, ac_phase_input,
                         display_blank_n, chain_in};

    always @(posedge core_clk) begin
        if (rst) begin
            sync1_reg    <= 8'h00;
            sync2_reg    <= 8'h00;
            clk_prev_reg <= 1'b0;
        end else begin
            sync1_reg    <= raw_in;
            sync2_reg    <= sync1_reg;
            clk_prev_reg <= sync2_reg[7];
        end
    end

    wire       clk_s   = sync2_reg[7];
    wire       dir_s   = sync2_reg[6];
    wire       phase_s = sync2_reg[5];
    wire       blank_s = sync2_reg[4];
    wire [3:0] din_s   = sync2_reg[3:0];
    // data is sampled as the scan clock falls; setup/hold at 100 ns covers sync skew
    wire       fall    = clk_prev_reg & ~clk_s;

    ////////////////////////////////////////////////////////////////////////
    // shift register: bits 0..79 and 80..159, no coupling between halves

    reg  [`LCS_ROWS_HI:0] sr_reg;
    reg  [`LCS_ROWS_HI:0] sr_next;

    always @* begin
        sr_next = sr_reg;
        if (fall) begin
            if (dir_s == `LCS_DIR_UP) begin
                sr_next[`LCS_HALF_HI:0] = {sr_reg[`LCS_HALF_HI-1:0], din_s[0]};
                sr_next[`LCS_ROWS_HI:`LCS_HALF_BITS] =
                    {sr_reg[`LCS_ROWS_HI-1:`LCS_HALF_BITS], din_s[2]};
            end else begin
                sr_next[`LCS_HALF_HI:0] = {din_s[1], sr_reg[`LCS_HALF_HI:1]};
                sr_next[`LCS_ROWS_HI:`LCS_HALF_BITS] =
                    {din_s[3], sr_reg[`LCS_ROWS_HI:`LCS_HALF_BITS+1]};
            end
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            sr_reg <= {`LCS_ROWS{1'b0}};
        end else begin
            sr_reg <= sr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // chain-end pins: far end drives, near end listens (oe low = driving)

    always @(posedge core_clk) begin
        if (rst) begin
            chain_out  <= 4'h0;
            chain_oe_n <= `LCS_OE_NONE;
        end else if (dir_s == `LCS_DIR_UP) begin
            chain_out  <= {sr_next[`LCS_ROWS_HI], 1'b0, sr_next[`LCS_HALF_HI], 1'b0};
            chain_oe_n <= `LCS_OE_UP;
        end else begin
            chain_out  <= {1'b0, sr_next[`LCS_HALF_BITS], 1'b0, sr_next[0]};
            chain_oe_n <= `LCS_OE_DOWN;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-row level selection

    genvar gi;
    generate
        for (gi = 0; gi < `LCS_ROWS; gi = gi + 1) begin : g_row
            lcs_level_sel u_sel (
                .scan_bit   (sr_reg[gi]),
                .ac_phase   (phase_s),
                .blank_n    (blank_s),
                .level_code (row_level_outputs[2*gi+1:2*gi])
            );
        end
    endgenerate

endmodule
`default_nettype wire

// [test/lcs_ctl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lcs_ctl_model (
    input  wire logic core_clk,
    output var  logic scan_shift_clock
);
    initial scan_shift_clock = 1'h0;
    // phases of 6 core cycles so the synced falling edge is never missed
    task automatic pulse();
        repeat (6) @(posedge core_clk);
        #5 scan_shift_clock = 1'h1;
        repeat (6) @(posedge core_clk);
        #5 scan_shift_clock = 1'h0;
    endtask
endmodule
`default_nettype wire

// [test/lcs_scan_driver_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module lcs_scan_driver_assertions (
    input wire logic         core_clk,
    input wire logic         rst,
    input wire logic         scan_shift_clock,
    input wire logic         shift_direction_select,
    input wire logic         ac_phase_input,
    input wire logic         display_blank_n,
    input wire logic [3:0]   chain_in,
    input wire logic [3:0]   chain_out,
    input wire logic [3:0]   chain_oe_n,
    input wire logic [319:0] row_level_outputs
);
    wire logic         d = shift_direction_select;
    wire logic         b = display_blank_n;
    wire logic         s = scan_shift_clock;
    wire logic [319:0] r = row_level_outputs;
    wire logic [319:0] ev = {160{2'h1}};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_oe_dir: assert property ((!rst && $stable(d))[*5] |-> chain_oe_n == (d ? 4'ha : 4'h5)) else $error("oe");
    a_out_quiet: assert property ((!rst && $stable(d))[*5] |-> (chain_out & chain_oe_n) == 4'h0) else $error("q");
    a_reset_vals: assert property ($fell(rst) |-> chain_oe_n == 4'hf && r == 320'h0) else $error("rst");
    a_blank_top: assert property ((!rst && !b)[*3] |-> r == 320'h0) else $error("blank");
    a_phase_low: assert property ((b && !ac_phase_input)[*3] |-> (r & ev) == ev) else $error("p0");
    a_phase_high: assert property ((b && ac_phase_input)[*3] |-> (r & ev) == 320'h0) else $error("p1");
    a_hold_high: assert property ((s && $stable(d))[*6] |-> $stable(chain_out)) else $error("hi");
    a_hold_low: assert property ((!s && $stable(d))[*6] |-> $stable(chain_out)) else $error("lo");
endmodule
bind lcs_scan_driver lcs_scan_driver_assertions u_chk (.*);
`default_nettype wire

// [test/test_lcs_scan_driver.sv]
`timescale 1ns/1ps
`default_nettype none
module test_lcs_scan_driver;
    logic         core_clk = 1'h0;
    logic         rst = 1'h1;
    logic         dir = 1'h0;
    logic         ac = 1'h0;
    logic         bl_n = 1'h1;
    logic [3:0]   cin = 4'h0;
    logic         scan;
    wire  [3:0]   cout;
    wire  [3:0]   oe_n;
    wire  [319:0] rows;
    int           bad_count = 0;
    int           total_checks = 0;
    // ac, blank_n, code of a set row, code of a clear row
    logic [5:0]   tbl [4] = '{6'h1d, 6'h32, 6'h00, 6'h20};
    always #25 core_clk = ~core_clk;
    lcs_ctl_model u_ctl (.core_clk(core_clk), .scan_shift_clock(scan));
    lcs_scan_driver u_dut (.core_clk(core_clk), .rst(rst), .scan_shift_clock(scan),
        .shift_direction_select(dir), .ac_phase_input(ac), .display_blank_n(bl_n),
        .chain_in(cin), .chain_out(cout), .chain_oe_n(oe_n), .row_level_outputs(rows));
    task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) u_ctl.pulse();
        repeat (4) @(posedge core_clk);
        #5;
    endtask
    initial begin
        step(0);
        repeat (4) @(posedge core_clk);
        #5 check("oe", oe_n, 4'hf);
        rst = 1'h0;
        cin = 4'h5;
        step(1);
        cin = 4'h0;
        foreach (tbl[i]) begin
            {ac, bl_n} = tbl[i][5:4];
            step(0);
            check("row1", {2'h0, rows[1:0]}, {2'h0, tbl[i][3:2]});
            check("row2", {2'h0, rows[3:2]}, {2'h0, tbl[i][1:0]});
        end
        {ac, bl_n} = 2'h1;
        check("oe", oe_n, 4'h5);
        step(78);
        check("far", cout, 4'h0);
        step(1);
        check("far", cout, 4'ha);
        dir = 1'h1;
        cin = 4'ha;
        step(1);
        check("oe", oe_n, 4'ha);
        check("rows", {rows[319:318], rows[159:158]}, 4'hf);
        cin = 4'h0;
        step(77);
        check("near", cout, 4'h0);
        step(1);
        check("near", cout, 4'h5);
        rst = 1'h1;
        step(0);
        check("oe", oe_n, 4'hf);
        check("out", cout, 4'h0);
        check("rst_rows", {3'h0, rows == 320'h0}, 4'h1);
        rst = 1'h0;
        step(0);
        check("clr_rows", {3'h0, rows == {160{2'h1}}}, 4'h1);
        close_out();
    end
    initial begin
        #300000;
        bad_count++;
        close_out();
    end
endmodule
`default_nettype wire
